/* File: verilog/flash_read_pkg.sv */
// shared constants and command decoding for the multi-line serial flash read link
package flash_read_pkg;

  // command opcodes understood by the read path
  localparam logic [7:0] OP_FAST_READ = 8'h0b; // single-line fast read
  localparam logic [7:0] OP_DUAL_OUT = 8'h3b; // dual_output_read
  localparam logic [7:0] OP_DUAL_IO = 8'hbb; // dual_io_read
  localparam logic [7:0] OP_QUAD_OUT = 8'h6b; // quad_output_read
  localparam logic [7:0] OP_QUAD_IO = 8'heb; // quad_io_read
  localparam logic [7:0] OP_ENTER_WIDE = 8'hb7; // enter_wide_address

  // address lengths in bits
  localparam logic [5:0] ADDR_NARROW_BITS = 6'h18; // 3-byte default
  localparam logic [5:0] ADDR_WIDE_BITS = 6'h20; // 4-byte after wide mode
  localparam logic [5:0] OPCODE_BITS = 6'h08;

  // lane counts
  localparam logic [2:0] LANES_1 = 3'h1;
  localparam logic [2:0] LANES_2 = 3'h2;
  localparam logic [2:0] LANES_4 = 3'h4;

  // default dummy clocks per command
  localparam logic [3:0] DUMMY_SINGLE_OUT = 4'h8; // fast, dual-out, quad-out reads
  localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
  // dummy clocks chosen by the two-bit dummy-count field (codes 01, 10, 11)
  localparam logic [3:0] DUMMY_DC_01 = 4'h4;
  localparam logic [3:0] DUMMY_DC_10 = 4'h8;
  localparam logic [3:0] DUMMY_DC_11 = 4'ha;
  localparam logic [1:0] DC_DEFAULT = 2'h0;
  localparam logic [1:0] DC_CODE_01 = 2'h1;
  localparam logic [1:0] DC_CODE_10 = 2'h2;

  // array model: address width and content seed
  localparam int MEM_AW = 16;
  localparam logic [7:0] MEM_SEED = 8'h5a;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // serial clock derived by the controller
  localparam int HCLK_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  localparam logic [2:0] SCLK_LAST = 3'(SCLK_PERIOD_NS / HCLK_PERIOD_NS - 1);
  localparam logic [2:0] SCLK_RISE = 3'(SCLK_PERIOD_NS / HCLK_PERIOD_NS / 2);
  localparam logic [2:0] SCLK_LAUNCH = 3'h0;

  // controller register map (byte addresses)
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_WIDE_BIT = 8;
  localparam int CMD_QPI_BIT = 9;
  localparam int CMD_DC_LSB = 10;
  localparam int CMD_LEN_LSB = 12;
  localparam int CMD_START_BIT = 16;
  localparam int CMD_WIDTH = 14;
  // status register fields
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;

  // true for the read commands handled here
  function automatic logic is_read(input logic [7:0] op);
    return (op == OP_FAST_READ) || (op == OP_DUAL_OUT) || (op == OP_DUAL_IO)
      || (op == OP_QUAD_OUT) || (op == OP_QUAD_IO);
  endfunction

  // lanes used by address and dummy phases
  function automatic logic [2:0] addr_lanes(input logic [7:0] op);
    case (op)
      OP_DUAL_IO: return LANES_2;
      OP_QUAD_IO: return LANES_4;
      default: return LANES_1;
    endcase
  endfunction

  // lanes used by the data-out phase
  function automatic logic [2:0] data_lanes(input logic [7:0] op);
    case (op)
      OP_DUAL_OUT, OP_DUAL_IO: return LANES_2;
      OP_QUAD_OUT, OP_QUAD_IO: return LANES_4;
      default: return LANES_1;
    endcase
  endfunction

  // dummy clocks: the field only steers the multi-line address reads
  function automatic logic [3:0] dummy_clocks(input logic [7:0] op, input logic [1:0] dc);
    if (op == OP_DUAL_IO || op == OP_QUAD_IO)
    begin
      case (dc)
        DC_DEFAULT: return (op == OP_DUAL_IO) ? DUMMY_DUAL_IO : DUMMY_QUAD_IO;
        DC_CODE_01: return DUMMY_DC_01;
        DC_CODE_10: return DUMMY_DC_10;
        default: return DUMMY_DC_11;
      endcase
    end
    return DUMMY_SINGLE_OUT;
  endfunction

  // log2 of a lane count, used to divide bit counts into clocks
  function automatic logic [1:0] lane_shift(input logic [2:0] lanes);
    case (lanes)
      LANES_2: return 2'h1;
      LANES_4: return 2'h2;
      default: return 2'h0;
    endcase
  endfunction

endpackage

/* File: verilog/flash_link_if.sv */
// link between the serial flash controller and the flash read device
`timescale 1ns/1ps
interface flash_link_if;
  logic cs_n; // chip select, active low, driven by the controller
  logic sclk; // serial clock, driven by the controller
  logic [3:0] host_out; // controller drive values for data_pin_3..0
  logic [3:0] host_oe; // controller drive enables
  logic [3:0] dev_out; // device drive values
  logic [3:0] dev_oe; // device drive enables
  logic [3:0] data_pin; // resolved level of data_pin_3..0

  // wire resolution; an undriven pin floats high through a pull-up
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_pin
      assign data_pin[i] = dev_oe[i] ? dev_out[i] : (host_oe[i] ? host_out[i] : 1'b1);
    end
  endgenerate

  modport device (input cs_n, input sclk, input data_pin, output dev_out, output dev_oe);
  modport host (output cs_n, output sclk, output host_out, output host_oe, input data_pin);
endinterface

/* File: verilog/flash_read_device.sv */
// serial flash read-command slave: opcode, address, dummy and data-out phases
//
// Overview of operation
// - sample on sclk rise, drive on fall
// - any start address, increment per byte
// - address counter wraps to zero
// - 3-byte address unless wide mode
// - fast read: 8 dummies, data on pin 1
// - chip select high ends read, stop driving
// - reads ignored while internal cycle busy
// - dual output: single-line setup, two-bit data
// - dual I/O: two bits address onward
// - host sets quad enable before quad output
// - quad output: 8 dummies, four-bit data
// - nibble MSB on data_pin_3
// - host sets quad enable before quad I/O
// - quad I/O: four-bit address, 6 dummies
// - quad I/O accepted in quad command mode
// - dummy count from two-bit field
// - host drives pins during indicator clocks
// - host avoids toggling indicator pattern
// - enter-wide command sets wide_address_flag
`timescale 1ns/1ps
module flash_read_device (
  input wire logic hclk,
  input wire logic hresetn,
  flash_link_if.device link,
  input wire logic quad_enable_bit,
  input wire logic write_in_progress,
  input wire logic dummy_count_lo,
  input wire logic dummy_count_hi,
  input wire logic [7:0] extended_address_reg,
  input wire logic quad_command_mode,
  output logic wide_address_flag
);

  // command sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_OPCODE = 6'b000010,
    ST_ADDR = 6'b000100,
    ST_DUMMY = 6'b001000,
    ST_DATA = 6'b010000,
    ST_IGNORE = 6'b100000
  } dev_state_t;

  // synchronisers for everything arriving from the link
  logic sclk_meta; // first stage, read only by sclk_sync
  logic sclk_sync; // synchronised serial clock
  logic sclk_prev; // previous synchronised value, for edges
  logic cs_meta; // first stage of chip select
  logic cs_sync; // synchronised chip select (active low)
  logic [3:0] pin_meta; // first stage of data pins
  logic [3:0] pin_sync; // synchronised data pins

  // sequencer state
  dev_state_t state;
  logic [7:0] op_reg; // opcode being shifted in, then held
  logic [31:0] addr_sr; // address being shifted in
  logic [5:0] bit_cnt; // bits left in opcode or address phase
  logic [3:0] dummy_left; // dummy clocks left
  logic [flash_read_pkg::MEM_AW-1:0] rd_ptr; // next array byte to send
  logic [7:0] out_sr; // byte being shifted out
  logic [3:0] out_left; // bits of out_sr still to send

  // decoded helpers
  logic sclk_rise;
  logic sclk_fall;
  logic cs_active;
  logic [2:0] op_lanes;
  logic [2:0] a_lanes;
  logic [2:0] d_lanes;
  logic [7:0] next_op;
  logic [31:0] next_addr;
  logic [31:0] full_addr;
  logic [7:0] cur_byte;
  logic op_done;
  logic accept_read;

  // array content: a fixed pattern of the address, so reads are checkable
  function automatic logic [7:0] mem_byte(input logic [flash_read_pkg::MEM_AW-1:0] a);
    return a[7:0] ^ a[flash_read_pkg::MEM_AW-1:8] ^ flash_read_pkg::MEM_SEED;
  endfunction

  // drive values for a nibble on the active lanes; single-line data leaves on pin 1
  function automatic logic [3:0] lane_bits(input logic [2:0] lanes, input logic [3:0] nib);
    case (lanes)
      flash_read_pkg::LANES_1: return {2'b00, nib[3], 1'b0};
      flash_read_pkg::LANES_2: return {2'b00, nib[3:2]};
      default: return nib;
    endcase
  endfunction

  // enables matching lane_bits
  function automatic logic [3:0] lane_mask(input logic [2:0] lanes);
    case (lanes)
      flash_read_pkg::LANES_1: return 4'h2;
      flash_read_pkg::LANES_2: return 4'h3;
      default: return 4'hf;
    endcase
  endfunction

  // two flip-flops on every link input before any logic looks at it
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end
    else
    begin
      sclk_meta <= link.sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      cs_meta <= link.cs_n;
      cs_sync <= cs_meta;
      pin_meta <= link.data_pin;
      pin_sync <= pin_meta;
    end
  end

  // edge detection on the synchronised clock only
  assign sclk_rise = sclk_sync & ~sclk_prev;
  assign sclk_fall = ~sclk_sync & sclk_prev;
  assign cs_active = ~cs_sync;

  // opcode arrives on one line, or four in quad command mode
  assign op_lanes = quad_command_mode ? flash_read_pkg::LANES_4 : flash_read_pkg::LANES_1;
  assign a_lanes = flash_read_pkg::addr_lanes(op_reg);
  assign d_lanes = flash_read_pkg::data_lanes(op_reg);

  // shift paths: single line on data_pin_0, wider lanes MSB first from the top pin
  assign next_op = quad_command_mode ? {op_reg[3:0], pin_sync} : {op_reg[6:0], pin_sync[0]};
  always_comb
  begin
    case (a_lanes)
      flash_read_pkg::LANES_2: next_addr = {addr_sr[29:0], pin_sync[1:0]};
      flash_read_pkg::LANES_4: next_addr = {addr_sr[27:0], pin_sync};
      default: next_addr = {addr_sr[30:0], pin_sync[0]};
    endcase
  end

  // narrow addresses take their top byte from the extended address register
  assign full_addr = wide_address_flag ? next_addr
    : {extended_address_reg, next_addr[23:0]};

  assign op_done = (state == ST_OPCODE) && sclk_rise && (bit_cnt == 6'(op_lanes));

  // a read is refused while busy, outside its mode, or quad without quad enable
  assign accept_read = flash_read_pkg::is_read(next_op) && !write_in_progress
    && (!quad_command_mode || next_op == flash_read_pkg::OP_QUAD_IO)
    && (quad_enable_bit
    || flash_read_pkg::data_lanes(next_op) != flash_read_pkg::LANES_4);

  // byte source: fresh array byte when the previous one is exhausted
  assign cur_byte = (out_left == 4'h0) ? mem_byte(rd_ptr) : out_sr;

  // command sequencer; chip select high aborts any phase at once
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= ST_IDLE;
      op_reg <= 8'h00;
      addr_sr <= 32'h0;
      bit_cnt <= 6'h0;
      dummy_left <= 4'h0;
      rd_ptr <= '0;
      out_sr <= 8'h00;
      out_left <= 4'h0;
    end
    else if (!cs_active)
    begin
      state <= ST_IDLE;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          // chip select just fell: expect an opcode
          state <= ST_OPCODE;
          bit_cnt <= flash_read_pkg::OPCODE_BITS;
        end
        ST_OPCODE:
        begin
          if (sclk_rise)
          begin
            op_reg <= next_op;
            bit_cnt <= bit_cnt - 6'(op_lanes);
          end
          if (op_done)
          begin
            if (accept_read)
            begin
              state <= ST_ADDR;
              bit_cnt <= wide_address_flag ? flash_read_pkg::ADDR_WIDE_BITS
                : flash_read_pkg::ADDR_NARROW_BITS;
            end
            else
            begin
              // unsupported, refused, or the one-byte wide-address command
              state <= ST_IGNORE;
            end
          end
        end
        ST_ADDR:
        begin
          if (sclk_rise)
          begin
            addr_sr <= next_addr;
            bit_cnt <= bit_cnt - 6'(a_lanes);
            if (bit_cnt == 6'(a_lanes))
            begin
              state <= ST_DUMMY;
              rd_ptr <= full_addr[flash_read_pkg::MEM_AW-1:0];
              dummy_left <= flash_read_pkg::dummy_clocks(op_reg,
                {dummy_count_hi, dummy_count_lo});
            end
          end
        end
        ST_DUMMY:
        begin
          // pins stay released; data starts on the fall after the last dummy
          if (sclk_rise)
          begin
            dummy_left <= dummy_left - 4'h1;
            if (dummy_left == 4'h1)
            begin
              state <= ST_DATA;
              out_left <= 4'h0;
            end
          end
        end
        ST_DATA:
        begin
          if (sclk_fall)
          begin
            out_sr <= cur_byte << d_lanes;
            if (out_left == 4'h0)
            begin
              // counter is exactly the array width, so the top address rolls to 0
              rd_ptr <= rd_ptr + 1'b1;
              out_left <= flash_read_pkg::BYTE_BITS - 4'(d_lanes);
            end
            else
            begin
              out_left <= out_left - 4'(d_lanes);
            end
          end
        end
        ST_IGNORE:
        begin
          // wait for chip select to rise
          state <= ST_IGNORE;
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // pin drivers: load on sclk fall inside the data phase, cleared as soon as it ends or chip select rises
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      link.dev_out <= 4'h0;
      link.dev_oe <= 4'h0;
    end
    else if (!cs_active || state != ST_DATA)
    begin
      link.dev_out <= 4'h0;
      link.dev_oe <= 4'h0;
    end
    else if (sclk_fall)
    begin
      link.dev_out <= lane_bits(d_lanes, cur_byte[7:4]);
      link.dev_oe <= lane_mask(d_lanes);
    end
  end

  // wide-address mode, left only by reset in this block
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wide_address_flag <= 1'b0;
    end
    else if (op_done && next_op == flash_read_pkg::OP_ENTER_WIDE)
    begin
      wide_address_flag <= 1'b1;
    end
  end

endmodule // flash_read_device

/* File: verilog/flash_read_host.sv */
// serial flash read controller: AHB-Lite registers on one side, flash link on the other
`timescale 1ns/1ps
module flash_read_host (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  flash_link_if.host link
);

  // link sequencer states
  typedef enum logic [4:0] {
    HS_IDLE = 5'b00001,
    HS_OPC = 5'b00010,
    HS_ADR = 5'b00100,
    HS_DUM = 5'b01000,
    HS_DAT = 5'b10000
  } host_state_t;

  host_state_t state;
  logic [flash_read_pkg::CMD_WIDTH-1:0] cmd_reg; // opcode, wide, qpi, dummy code, length
  logic [31:0] addr_reg; // start address
  logic [31:0] rdata_reg; // received bytes, last one in bits 7:0
  logic busy; // transfer running
  logic done; // sticky: transfer finished
  logic wr_pend; // write data phase pending
  logic [7:0] wr_addr; // address of the pending write
  logic [39:0] tx_sr; // opcode and address, MSB first
  logic [5:0] clk_left; // serial clocks left in the phase
  logic [2:0] div_cnt; // position within one serial clock period
  logic [3:0] pin_meta; // first stage, read only by pin_sync
  logic [3:0] pin_sync;

  logic [7:0] op;
  logic [2:0] cur_lanes;
  logic [2:0] d_lanes;
  logic start;
  logic [5:0] len_bits;

  assign op = cmd_reg[flash_read_pkg::CMD_OP_LSB +: 8];
  assign d_lanes = flash_read_pkg::data_lanes(op);
  assign len_bits = {1'b0, cmd_reg[flash_read_pkg::CMD_LEN_LSB +: 2], 3'b000} + 6'h08;
  // a start bit written while idle launches a transfer; writes while busy are dropped
  assign start = wr_pend && wr_addr == flash_read_pkg::REG_CMD && !busy
    && hwdata[flash_read_pkg::CMD_START_BIT];

  // lanes driven in the present phase
  always_comb
  begin
    case (state)
      HS_OPC: cur_lanes = cmd_reg[flash_read_pkg::CMD_QPI_BIT] ? flash_read_pkg::LANES_4
        : flash_read_pkg::LANES_1;
      HS_ADR, HS_DUM: cur_lanes = flash_read_pkg::addr_lanes(op);
      default: cur_lanes = d_lanes;
    endcase
  end

  // read mux for the bus
  function automatic logic [31:0] reg_read(input logic [7:0] a, input logic [13:0] c,
    input logic [31:0] ad, input logic [31:0] rd, input logic b, input logic d);
    case (a)
      flash_read_pkg::REG_CMD: return {18'h0, c};
      flash_read_pkg::REG_ADDR: return ad;
      flash_read_pkg::REG_DATA: return rd;
      flash_read_pkg::REG_STATUS: return {30'h0, d, b};
      default: return 32'h0;
    endcase
  endfunction

  // AHB-Lite slave: zero wait states, always OKAY, read data registered in address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      cmd_reg <= '0;
      addr_reg <= 32'h0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= hsel && htrans[1] && hready && hwrite;
      if (hsel && htrans[1] && hready)
      begin
        wr_addr <= haddr[7:0];
        if (!hwrite)
        begin
          hrdata <= reg_read(haddr[7:0], cmd_reg, addr_reg, rdata_reg, busy, done);
        end
      end
      if (wr_pend && !busy)
      begin
        if (wr_addr == flash_read_pkg::REG_CMD)
        begin
          cmd_reg <= hwdata[flash_read_pkg::CMD_WIDTH-1:0];
        end
        if (wr_addr == flash_read_pkg::REG_ADDR)
        begin
          addr_reg <= hwdata;
        end
      end
    end
  end

  // link pins enter through two flip-flops
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_meta <= 4'h0;
      pin_sync <= 4'h0;
    end
    else
    begin
      pin_meta <= link.data_pin;
      pin_sync <= pin_meta;
    end
  end

  // link sequencer: launch at period start, rise mid-period, sample and step at the end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= HS_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.host_out <= 4'h0;
      link.host_oe <= 4'h0;
      tx_sr <= 40'h0;
      clk_left <= 6'h0;
      div_cnt <= 3'h0;
      rdata_reg <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else if (state == HS_IDLE)
    begin
      if (start)
      begin
        state <= HS_OPC;
        link.cs_n <= 1'b0;
        busy <= 1'b1;
        done <= 1'b0;
        div_cnt <= flash_read_pkg::SCLK_LAUNCH;
        tx_sr <= hwdata[flash_read_pkg::CMD_WIDE_BIT] ? {hwdata[7:0], addr_reg}
          : {hwdata[7:0], addr_reg[23:0], 8'h00};
        clk_left <= hwdata[flash_read_pkg::CMD_QPI_BIT] ? 6'h02 : 6'h08;
      end
    end
    else
    begin
      div_cnt <= div_cnt + 3'h1;
      if (div_cnt == flash_read_pkg::SCLK_LAUNCH)
      begin
        link.sclk <= 1'b0;
        // host keeps its lanes driven through the dummy clocks (zero indicator)
        link.host_oe <= (state == HS_DAT) ? 4'h0 : ((cur_lanes == flash_read_pkg::LANES_4)
          ? 4'hf : ((cur_lanes == flash_read_pkg::LANES_2) ? 4'h3 : 4'h1));
        if (state == HS_DUM)
        begin
          link.host_out <= 4'h0;
        end
        else
        begin
          link.host_out <= (cur_lanes == flash_read_pkg::LANES_4) ? tx_sr[39:36]
            : ((cur_lanes == flash_read_pkg::LANES_2) ? {2'b00, tx_sr[39:38]}
            : {3'b000, tx_sr[39]});
        end
      end
      if (div_cnt == flash_read_pkg::SCLK_RISE)
      begin
        link.sclk <= 1'b1;
      end
      if (div_cnt == flash_read_pkg::SCLK_LAST)
      begin
        clk_left <= clk_left - 6'h1;
        if (state == HS_OPC || state == HS_ADR)
        begin
          tx_sr <= tx_sr << cur_lanes;
        end
        if (state == HS_DAT)
        begin
          rdata_reg <= (d_lanes == flash_read_pkg::LANES_4) ? {rdata_reg[27:0], pin_sync}
            : ((d_lanes == flash_read_pkg::LANES_2) ? {rdata_reg[29:0], pin_sync[1:0]}
            : {rdata_reg[30:0], pin_sync[1]});
        end
        if (clk_left == 6'h1)
        begin
          if (state == HS_OPC && flash_read_pkg::is_read(op))
          begin
            state <= HS_ADR;
            // address clocks follow the address lanes, not the opcode lanes
            clk_left <= (cmd_reg[flash_read_pkg::CMD_WIDE_BIT] ? flash_read_pkg::ADDR_WIDE_BITS
              : flash_read_pkg::ADDR_NARROW_BITS)
              >> flash_read_pkg::lane_shift(flash_read_pkg::addr_lanes(op));
          end
          else if (state == HS_ADR)
          begin
            state <= HS_DUM;
            clk_left <= {2'b00, flash_read_pkg::dummy_clocks(op,
              cmd_reg[flash_read_pkg::CMD_DC_LSB +: 2])};
          end
          else if (state == HS_DUM)
          begin
            state <= HS_DAT;
            link.host_oe <= 4'h0;
            clk_left <= len_bits >> flash_read_pkg::lane_shift(d_lanes);
          end
          else
          begin
            // end of command: raise chip select with the clock low
            state <= HS_IDLE;
            link.cs_n <= 1'b1;
            link.sclk <= 1'b0;
            link.host_oe <= 4'h0;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule // flash_read_host

/* File: test/flash_link_checker.sv */
// timing checks on the flash link between controller and device
`timescale 1ns/1ps
module flash_link_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] low_cnt; // cycles since select fell, saturating
  // setup span of a frame; the shortest setup is well over 80 cycles
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_cnt <= 8'h00;
    else if (cs_n)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
  end
  a_idle_quiet: assert property (cs_n [*4] |-> dev_oe == 4'h0)
    else $error("device drives while deselected");
  a_no_contend: assert property ((dev_oe & host_oe) == 4'h0)
    else $error("both ends drive one pin");
  a_hold_high: assert property (sclk && $past(sclk) |-> $stable(dev_out))
    else $error("device data moved while clock high");
  a_lane_set: assert property (dev_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("device drives an odd lane set");
  a_clock_park: assert property (cs_n && $past(cs_n) |-> !sclk)
    else $error("clock runs outside a frame");
  a_late_drive: assert property ($rose(|dev_oe) |-> low_cnt > 8'h50)
    else $error("device drives before setup ends");
  a_quick_stop: assert property ($rose(cs_n) |-> ##[1:4] dev_oe == 4'h0)
    else $error("device kept driving after deselect");
  a_frame_start: assert property ($fell(cs_n) |-> !sclk)
    else $error("frame began with clock high");
endmodule // flash_link_checker

/* File: test/serial_flash_multi_io_read_tb.sv */
// self-checking bench: controller and device joined, reads compared to a model
`timescale 1ns/1ps
module serial_flash_multi_io_read_tb;
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hready, hresp, wide_address_flag;
  logic [1:0] htrans = 2'h0, dummy_code = 2'h0, dc;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic quad_enable_bit = 1'b1, write_in_progress = 1'b0, quad_command_mode = 1'b0;
  logic [7:0] ext_addr = 8'h00;
  int n_errors = 0, n_checks = 0;
  localparam logic [7:0] OPS [5] = '{flash_read_pkg::OP_FAST_READ, flash_read_pkg::OP_DUAL_OUT,
    flash_read_pkg::OP_DUAL_IO, flash_read_pkg::OP_QUAD_OUT, flash_read_pkg::OP_QUAD_IO};
  flash_link_if link ();
  flash_read_host flash_read_host_inst (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(link));
  flash_read_device flash_read_device_inst (.hclk(hclk), .hresetn(hresetn), .link(link),
    .quad_enable_bit(quad_enable_bit), .write_in_progress(write_in_progress),
    .dummy_count_lo(dummy_code[0]), .dummy_count_hi(dummy_code[1]),
    .extended_address_reg(ext_addr), .quad_command_mode(quad_command_mode),
    .wide_address_flag(wide_address_flag));
  flash_link_checker flash_link_checker_inst (.hclk(hclk), .hresetn(hresetn),
    .cs_n(link.cs_n), .sclk(link.sclk), .host_oe(link.host_oe), .dev_out(link.dev_out),
    .dev_oe(link.dev_oe));
  always #10 hclk = ~hclk;
  // one single word transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // expected four bytes; the 16-bit counter wraps to zero past the top
  function automatic logic [31:0] model(input logic [31:0] a);
    logic [31:0] w = 32'h0;
    logic [15:0] p;
    for (int i = 0; i < 4; i++)
    begin
      p = a[15:0] + 16'(i);
      w = {w[23:0], p[7:0] ^ p[15:8] ^ flash_read_pkg::MEM_SEED};
    end
    return w;
  endfunction
  // address, command with start and four-byte length, poll done, fetch data
  task automatic run(input logic [7:0] op, input logic [31:0] adr, input logic q,
    input logic wide, output logic [31:0] r);
    ahb(1'b1, 8'h04, adr, r);
    ahb(1'b1, 8'h00, {15'h0, 1'b1, 2'h0, 2'h3, dc, q, wide, op}, r);
    r = 32'h0;
    for (int i = 0; i < 2000 && r[1] !== 1'b1; i++)
      ahb(1'b0, 8'h0c, 32'h0, r);
    ahb(1'b0, 8'h08, 32'h0, r);
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    logic [31:0] r, a;
    void'($urandom(95343));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < 5; k++)
    begin
      dc = 2'($urandom);
      a = $urandom;
      dummy_code <= dc;
      ext_addr <= 8'($urandom);
      run(OPS[k], a, 1'b0, 1'b0, r);
      check(r, model(a));
    end
    quad_command_mode <= 1'b1;
    run(OPS[4], a, 1'b1, 1'b0, r);
    check(r, model(a));
    quad_command_mode <= 1'b0;
    write_in_progress <= 1'b1;
    run(OPS[0], a, 1'b0, 1'b0, r);
    check(r, 32'hffffffff);
    write_in_progress <= 1'b0;
    quad_enable_bit <= 1'b0;
    run(OPS[3], a, 1'b0, 1'b0, r);
    check(r, 32'hffffffff);
    run(OPS[4], a, 1'b0, 1'b0, r);
    check(r, 32'hffffffff);
    quad_enable_bit <= 1'b1;
    run(OPS[1], 32'h0000fffe, 1'b0, 1'b0, r);
    check(r, model(32'h0000fffe));
    ahb(1'b0, 8'h10, 32'h0, r);
    check(r, 32'h0);
    check({31'h0, hresp}, 32'h0);
    run(flash_read_pkg::OP_ENTER_WIDE, 32'h0, 1'b0, 1'b0, r);
    check({31'h0, wide_address_flag}, 32'h1);
    a = $urandom;
    run(OPS[2], a, 1'b0, 1'b1, r);
    check(r, model(a));
    report_and_stop;
  end
  initial
  begin
    #1200000;
    n_errors++;
    report_and_stop;
  end
endmodule // serial_flash_multi_io_read_tb
